// [hw/icd_pkg.sv]
// Package for the instruction class decoder: opcode constants, class codes
// and the carrier structs. Assumes a 32-bit core with word-aligned fetch.
package icd_pkg;

  // Instruction word geometry
  localparam int ICD_WORD_W = 32;
  localparam int ICD_PO_MSB = 31;
  localparam int ICD_PO_LSB = 26;
  localparam int ICD_XO_MSB = 10;
  localparam int ICD_XO_LSB = 1;
  localparam int ICD_XO5_MSB = 5;
  localparam int ICD_XO5_LSB = 1;
  localparam int ICD_ALIGN_LSB = 2;
  localparam int ICD_REGSET_N = 32;
  localparam int ICD_RT_LSB = 21;
  localparam int ICD_RA_LSB = 16;
  localparam int ICD_RB_LSB = 11;

  // Zero primary opcode, then the primary opcodes that carry an extended opcode
  localparam logic [5:0] ICD_PO_NONE = 6'h00;
  localparam logic [5:0] ICD_PO_SC = 6'h11;
  localparam logic [5:0] ICD_PO_BRCR = 6'h13;
  localparam logic [5:0] ICD_PO_INTX = 6'h1f;
  localparam logic [5:0] ICD_PO_FPS = 6'h3b;
  localparam logic [5:0] ICD_PO_FPD = 6'h3f;

  // Extended opcodes of the unimplemented optional instructions
  localparam logic [4:0] ICD_XO_SQRT = 5'h16;
  localparam logic [9:0] ICD_XO_TLBALL = 10'h172;

  // Reset value of the class register in the output stage
  localparam logic [1:0] ICD_CLASS_RST = 2'h0;

  // Instruction class codes
  typedef enum logic [1:0] {
    ICD_CLASS_DEFINED = 2'b00,
    ICD_CLASS_RESERVED = 2'b01,
    ICD_CLASS_ILLEGAL = 2'b10
  } icd_class_e;

  // Fetch-side request
  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [31:0] addr;
  } icd_fetch_s;

  // Decode result to execution and exception logic
  typedef struct packed {
    logic valid;
    icd_class_e iclass;
    logic exc_req;
    logic misalign;
    logic mem_op;
    logic fp_op;
    logic [4:0] rt;
    logic [4:0] ra;
    logic [4:0] rb;
  } icd_result_s;

endpackage

// [hw/icd_xo_table.sv]
// Extended-opcode lookup for the system and float primary opcodes.
// Assumes the caller has already split out the primary and extended fields.
`timescale 1ns/1ps
module icd_xo_table
  import icd_pkg::*;
(
  // Opcode fields
  input wire logic [5:0] po,
  input wire logic [9:0] xo,
  // Lookup answer
  output logic assigned
);

  // Assigned extended opcodes for this 32-bit core
  always_comb begin
    assigned = 1'b0;
    unique case (po)
      ICD_PO_SC: assigned = 1'b0;
      ICD_PO_FPS: begin
        unique case (xo[4:0])
          5'h12, 5'h14, 5'h15, 5'h18, 5'h19, 5'h1c, 5'h1d,
          5'h1e, 5'h1f: assigned = 1'b1;
          default: assigned = 1'b0;
        endcase
      end
      ICD_PO_FPD: begin
        unique case (xo[4:0])
          5'h12, 5'h14, 5'h15, 5'h17, 5'h19, 5'h1a, 5'h1c, 5'h1d,
          5'h1e, 5'h1f: assigned = 1'b1;
          default: begin
            unique case (xo)
              10'h000, 10'h00c, 10'h00e, 10'h00f, 10'h020, 10'h026,
              10'h028, 10'h040, 10'h046, 10'h048, 10'h086,
              10'h088, 10'h108, 10'h247, 10'h2c7: assigned = 1'b1;
              default: assigned = 1'b0;
            endcase
          end
        endcase
      end
      default: assigned = 1'b0;
    endcase
  end

endmodule // icd_xo_table

// [hw/icd_decoder.sv]
// Instruction class decoder: classifies each fetched word as defined,
// reserved or illegal and raises a program exception request.
// Assumes fetch data is on the core clock; results are one cycle later.
//
// Notes on behaviour
// RL1: Words are four bytes, word aligned; a misaligned fetch is flagged.
// RL2: Thirty-two integer registers serve byte, half-word and word transfers.
// RL3: Thirty-two float registers serve word and double-word transfers.
// RL4: Arithmetic and logic never touch memory; only loads and stores do.
// RL5: Class from primary and extended opcode; unmatched ones are illegal.
// RL6: Primary opcodes 1,4,5,6,9,22,56,60,61 decode as illegal.
// RL7: Primary opcodes 2,30,58,62 are 64-bit only and decode illegal.
// RL8: Unassigned extended opcodes under 17,19,31,59,63 decode illegal.
// RL9: Extended opcodes of 64-bit-only instructions decode illegal here.
// RL10: An all-zero word is always illegal.
// RL11: Zero primary opcode with other bits set is reserved.
// RL12: Any illegal instruction requests the illegal-instruction exception.
// RL13: Square roots and invalidate-all-TLB are unimplemented and trap.
// RL14: Unimplemented reserved instructions raise the program exception.
// RL15: Required custom encodings are unimplemented and treated as reserved.
// RL16: Bad reserved-field bits never raise privilege or program rights.
// RL17: Class code and exception flag are produced together each decode cycle.
`timescale 1ns/1ps
module icd_decoder
  import icd_pkg::*;
#(
  parameter int REGSET_N = ICD_REGSET_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch side
  input wire icd_fetch_s fetch,
  // Execution and exception side
  output icd_result_s result
);

  // Field extraction helpers
  function automatic logic [5:0] prim_op(input logic [31:0] w);
    prim_op = w[ICD_PO_MSB:ICD_PO_LSB];
  endfunction

  function automatic logic [4:0] reg_field(input logic [31:0] w,
                                           input int lsb);
    reg_field = 5'(w >> lsb) & 5'(REGSET_N - 1);
  endfunction

  // Primary opcodes that are only load or store
  function automatic logic is_load_store(input logic [5:0] po);
    is_load_store = (po >= 6'h20) && (po <= 6'h37);
  endfunction

  function automatic logic is_fp_load_store(input logic [5:0] po);
    is_fp_load_store = (po >= 6'h30) && (po <= 6'h37);
  endfunction

  // Assigned extended opcodes under the integer group opcode
  function automatic logic intx_assigned(input logic [9:0] x);
    unique case (x)
      10'h000, 10'h008, 10'h00a, 10'h00b,
      10'h013, 10'h014, 10'h017, 10'h018,
      10'h01a, 10'h01c, 10'h020, 10'h028,
      10'h036, 10'h037, 10'h03c, 10'h04b,
      10'h053, 10'h056, 10'h057, 10'h068,
      10'h077, 10'h07c, 10'h088, 10'h08a,
      10'h090, 10'h092, 10'h096, 10'h097,
      10'h0b7, 10'h0c8, 10'h0ca, 10'h0d2,
      10'h0d7, 10'h0e2, 10'h0ea, 10'h0eb,
      10'h0f2, 10'h0f6, 10'h0f7, 10'h116,
      10'h117, 10'h11c, 10'h132, 10'h136,
      10'h137, 10'h13c, 10'h153, 10'h157,
      10'h173, 10'h177, 10'h19c, 10'h1b6,
      10'h1b7, 10'h1bc, 10'h1c3, 10'h1cb,
      10'h1d3, 10'h1d6, 10'h1dc, 10'h1eb,
      10'h200, 10'h208, 10'h215, 10'h216,
      10'h217, 10'h218, 10'h236, 10'h237,
      10'h253, 10'h255, 10'h256, 10'h257,
      10'h277, 10'h293, 10'h295, 10'h296,
      10'h297, 10'h2b7, 10'h2d5, 10'h2d7,
      10'h2f7, 10'h316, 10'h318, 10'h338,
      10'h356, 10'h392, 10'h396, 10'h39a,
      10'h3ba, 10'h3d6, 10'h3d7, 10'h3f6,
      10'h1e8, 10'h3e8, 10'h1ca, 10'h2e8,
      10'h2ea, 10'h3ca, 10'h3eb, 10'h1f6: intx_assigned = 1'b1;
      default: intx_assigned = 1'b0;
    endcase
  endfunction

  // Assigned extended opcodes under the branch and condition opcode
  function automatic logic brcr_assigned(input logic [9:0] x);
    unique case (x)
      10'h000, 10'h010, 10'h021, 10'h032,
      10'h081, 10'h096, 10'h0c1, 10'h0e1,
      10'h0ff, 10'h101, 10'h121, 10'h1a1,
      10'h1c1, 10'h210: brcr_assigned = 1'b1;
      default: brcr_assigned = 1'b0;
    endcase
  endfunction

  logic [5:0] po;
  logic [9:0] xo;
  logic xo_assigned;
  logic po_future;
  logic po_wide;
  logic po_extended;
  logic unimpl_opt;
  logic misalign;
  logic mem_op;
  logic fp_op;
  icd_class_e class_next;
  logic exc_next;
  logic xo_known;
  logic valid_reg;
  icd_class_e class_reg;
  logic exc_reg;
  logic misalign_reg;
  logic mem_reg;
  logic fp_reg;
  logic [4:0] rt_reg;
  logic [4:0] ra_reg;
  logic [4:0] rb_reg;
  icd_result_s result_next;

  assign po = prim_op(fetch.word);
  assign xo = fetch.word[ICD_XO_MSB:ICD_XO_LSB];

  // Extended-opcode lookup
  icd_xo_table u_xo_table (
    .po(po),
    .xo(xo),
    .assigned(xo_assigned)
  );

  // Integer and branch tables are local; the module keeps system and float
  assign xo_known = (po == ICD_PO_INTX) ? intx_assigned(xo) :
                    (po == ICD_PO_BRCR) ? brcr_assigned(xo) : xo_assigned;

  // Opcode groups
  always_comb begin
    po_future = 1'b0;
    po_wide = 1'b0;
    po_extended = 1'b0;
    unique case (po)
      6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16, 6'h38, 6'h3c,
      6'h3d: po_future = 1'b1; // RL6
      6'h02, 6'h1e, 6'h3a, 6'h3e: po_wide = 1'b1; // RL7
      ICD_PO_SC, ICD_PO_BRCR, ICD_PO_INTX, ICD_PO_FPS,
      ICD_PO_FPD: po_extended = 1'b1;
      default: begin
        po_future = 1'b0;
      end
    endcase
  end

  // Optional instructions that this core leaves to software
  assign unimpl_opt = ((po == ICD_PO_FPS || po == ICD_PO_FPD) &&
                       fetch.word[ICD_XO5_MSB:ICD_XO5_LSB] == ICD_XO_SQRT)
                    || (po == ICD_PO_INTX && xo == ICD_XO_TLBALL); // RL13

  // Word alignment of the fetch address
  assign misalign = |fetch.addr[ICD_ALIGN_LSB-1:0]; // RL1

  // Only load/store opcodes reach memory
  assign mem_op = is_load_store(po); // RL4
  assign fp_op = is_fp_load_store(po) || po == ICD_PO_FPS ||
                 po == ICD_PO_FPD;

  // Class decision, first match wins; the all-zero test leads because
  // an all-zero word also carries a zero primary opcode
  always_comb begin
    class_next = ICD_CLASS_DEFINED;
    if (fetch.word == '0) begin
      class_next = ICD_CLASS_ILLEGAL; // RL10
    end else if (po == ICD_PO_NONE) begin
      class_next = ICD_CLASS_RESERVED; // RL11 RL15
    end else if (po_future || po_wide) begin
      class_next = ICD_CLASS_ILLEGAL; // RL6 RL7
    end else if (unimpl_opt) begin
      class_next = ICD_CLASS_ILLEGAL; // RL13
    end else if (po_extended && !xo_known) begin
      class_next = ICD_CLASS_ILLEGAL; // RL5 RL8 RL9
    end else begin
      class_next = ICD_CLASS_DEFINED; // RL5
    end
  end

  // No reserved encoding is implemented, so every reserved one traps;
  // a trap never changes privilege, keeping results bounded
  assign exc_next = (class_next != ICD_CLASS_DEFINED) ||
                    misalign; // RL12 RL14 RL16 RL17

  // Result assembly; register numbers index the 32-entry sets
  always_comb begin
    result_next = '0;
    result_next.valid = fetch.valid;
    result_next.iclass = class_next; // RL17
    result_next.exc_req = fetch.valid && exc_next; // RL17
    result_next.misalign = fetch.valid && misalign; // RL1
    result_next.mem_op = mem_op && (class_next == ICD_CLASS_DEFINED);
    result_next.fp_op = fp_op && (class_next == ICD_CLASS_DEFINED);
    result_next.rt = reg_field(fetch.word, ICD_RT_LSB); // RL2 RL3
    result_next.ra = reg_field(fetch.word, ICD_RA_LSB); // RL2 RL3
    result_next.rb = reg_field(fetch.word, ICD_RB_LSB);
  end

  // Output stage, one flop group per concern
  // Result valid, the fetch strobe one cycle on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= result_next.valid;
    end
  end

  // Class code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      class_reg <= icd_class_e'(ICD_CLASS_RST);
    end else begin
      class_reg <= result_next.iclass; // RL17
    end
  end

  // Exception request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_reg <= 1'b0;
    end else begin
      exc_reg <= result_next.exc_req; // RL12 RL17
    end
  end

  // Misalignment flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misalign_reg <= 1'b0;
    end else begin
      misalign_reg <= result_next.misalign; // RL1
    end
  end

  // Memory access kind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg <= 1'b0;
    end else begin
      mem_reg <= result_next.mem_op; // RL4
    end
  end

  // Float access kind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_reg <= 1'b0;
    end else begin
      fp_reg <= result_next.fp_op;
    end
  end

  // Target register field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rt_reg <= 5'h00;
    end else begin
      rt_reg <= result_next.rt;
    end
  end

  // First source register field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ra_reg <= 5'h00;
    end else begin
      ra_reg <= result_next.ra;
    end
  end

  // Second source register field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_reg <= 5'h00;
    end else begin
      rb_reg <= result_next.rb;
    end
  end

  // Result port comes straight from the flops
  always_comb begin
    result = '0;
    result.valid = valid_reg;
    result.iclass = class_reg;
    result.exc_req = exc_reg;
    result.misalign = misalign_reg;
    result.mem_op = mem_reg;
    result.fp_op = fp_reg;
    result.rt = rt_reg;
    result.ra = ra_reg;
    result.rb = rb_reg;
  end

endmodule // icd_decoder

// [tb/icd_properties.sv]
// Checker for the instruction class decoder, one-cycle result stage.
// Assumes it is bound to icd_decoder and sees only its ports.
`timescale 1ns/1ps
module icd_properties
  import icd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire icd_fetch_s fetch,
  input wire icd_result_s result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Primary opcode of the word being taken
  wire logic [5:0] po = fetch.word[31:26];
  // Illegal answer with exception one cycle on
  sequence s_ill;
    ##1 result.valid && result.iclass == ICD_CLASS_ILLEGAL && result.exc_req;
  endsequence
  // Opcode classes, then exception, alignment, idle, register and ALU checks
  property p_zero;
    fetch.valid && fetch.word == 32'h0 |-> s_ill;
  endproperty
  property p_po0;
    fetch.valid && po == 6'h00 && fetch.word != 32'h0
      |=> result.iclass == ICD_CLASS_RESERVED && result.exc_req;
  endproperty
  property p_fut;
    fetch.valid && po inside {6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16,
      6'h38, 6'h3c, 6'h3d} |-> s_ill;
  endproperty
  property p_wide;
    fetch.valid && po inside {6'h02, 6'h1e, 6'h3a, 6'h3e} |-> s_ill;
  endproperty
  property p_sc;
    fetch.valid && po == ICD_PO_SC |-> s_ill;
  endproperty
  property p_sqrt;
    fetch.valid && (po == ICD_PO_FPS || po == ICD_PO_FPD)
      && fetch.word[5:1] == ICD_XO_SQRT |-> s_ill;
  endproperty
  property p_exc;
    result.valid && result.iclass != ICD_CLASS_DEFINED |-> result.exc_req;
  endproperty
  property p_mis;
    fetch.valid && fetch.addr[1:0] != 2'h0
      |=> result.misalign && result.exc_req;
  endproperty
  property p_idle;
    !fetch.valid |=> !result.valid && !result.exc_req;
  endproperty
  property p_regs;
    fetch.valid |=> result.rt == $past(fetch.word[25:21])
      && result.ra == $past(fetch.word[20:16]);
  endproperty
  property p_alu;
    fetch.valid && po == 6'h0e && fetch.addr[1:0] == 2'h0
      |=> result.iclass == ICD_CLASS_DEFINED && !result.mem_op
      && !result.exc_req;
  endproperty
  a_zero: assert property (p_zero) else $error("zero word");
  a_po0: assert property (p_po0) else $error("zero opcode");
  a_fut: assert property (p_fut) else $error("future opcode");
  a_wide: assert property (p_wide) else $error("wide opcode");
  a_sc: assert property (p_sc) else $error("opcode 17");
  a_sqrt: assert property (p_sqrt) else $error("square root");
  a_exc: assert property (p_exc) else $error("no exception");
  a_mis: assert property (p_mis) else $error("misaligned");
  a_idle: assert property (p_idle) else $error("idle result");
  a_regs: assert property (p_regs) else $error("register field");
  a_alu: assert property (p_alu) else $error("add immediate");
endmodule // icd_properties

bind icd_decoder icd_properties icd_properties_inst (.clk(clk),
  .rst_n(rst_n), .fetch(fetch), .result(result));

// [tb/icd_fetch_model.sv]
// Fetch stage model: offers one word a cycle, idles only when idle is called.
// Assumes callers step through clock edges one call at a time.
`timescale 1ns/1ps
module icd_fetch_model
  import icd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request to the decoder
  output icd_fetch_s fetch
);
  // Quiet at time zero
  initial fetch = '0;
  // Present one word just after the edge
  task automatic issue(input logic [31:0] w, input logic [31:0] a);
    @(posedge clk);
    #1;
    fetch = {1'b1, w, a};
  endtask
  // Released lines no longer show the last word
  task automatic idle();
    @(posedge clk);
    #1;
    fetch = {1'b0, ~fetch.word, ~fetch.addr};
  endtask
endmodule // icd_fetch_model

// [tb/testbench.sv]
// Self-checking bench for the instruction class decoder.
// Assumes the fetch model drives the decoder and a checker is bound.
`timescale 1ns/1ps
module testbench
  import icd_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  icd_fetch_s fetch;
  icd_result_s result;
  icd_result_s notes[$];
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h02de21e4;
  logic [31:0] r;
  logic [31:0] w;
  logic [5:0] ill[13] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16,
    6'h38, 6'h3c, 6'h3d, 6'h02, 6'h1e, 6'h3a, 6'h3e};
  logic [5:0] xpo[4] = '{ICD_PO_BRCR, ICD_PO_INTX, ICD_PO_FPS, ICD_PO_FPD};

  icd_fetch_model icd_fetch_model_inst (.clk(clk), .fetch(fetch));
  icd_decoder icd_decoder_inst (.clk(clk), .rst_n(rst_n), .fetch(fetch),
    .result(result));

  // Clock, 100 ns period
  always #50 clk = ~clk;

  // Next xorshift value
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Compare one field
  task automatic chk(input string n, input logic [14:0] e,
      input logic [14:0] g);
    tests_run++;
    if (e !== g) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Report and end the run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Note the expected result, then offer the word
  task automatic send(input logic [31:0] w, input logic [1:0] lo,
      input icd_class_e c, input logic [1:0] mf);
    icd_result_s e;
    logic [31:0] a;
    e = '0;
    e.valid = 1'b1;
    e.iclass = c;
    e.misalign = lo != 2'h0;
    e.exc_req = c != ICD_CLASS_DEFINED || e.misalign;
    {e.mem_op, e.fp_op} = mf;
    {e.rt, e.ra, e.rb} = w[25:11];
    notes.push_back(e);
    a = rnd();
    icd_fetch_model_inst.issue(w, {a[31:2], lo});
  endtask

  // Pair each valid result with the oldest note
  always @(negedge clk) begin
    icd_result_s e;
    if (rst_n === 1'b1 && result.valid !== 1'b0) begin
      e = notes.size() > 0 ? notes.pop_front() : '0;
      chk("flags", {12'h0, e.valid, e.exc_req, e.misalign},
        {12'h0, result.valid, result.exc_req, result.misalign});
      chk("class", {13'h0, e.iclass}, {13'h0, result.iclass});
      chk("regs", {e.rt, e.ra, e.rb},
        {result.rt, result.ra, result.rb});
      if (e.iclass === ICD_CLASS_DEFINED) begin
        chk("memfp", {13'h0, e.mem_op, e.fp_op},
          {13'h0, result.mem_op, result.fp_op});
      end
    end
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Main sequence, back to back with one idle gap
  initial begin
    repeat (8) @(posedge clk);
    chk("reset", 15'h0, {11'h0, result.valid, result.iclass,
      result.exc_req});
    #1 rst_n = 1'b1;
    send(32'h0, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    foreach (ill[i]) begin
      r = rnd();
      send({ill[i], r[25:0]}, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    end
    r = rnd();
    send({6'h00, r[25:1], 1'b1}, 2'h0, ICD_CLASS_RESERVED, 2'h0);
    send({ICD_PO_SC, r[25:0]}, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    foreach (xpo[j]) begin
      w = {xpo[j], r[25:11], 10'h3e0, r[0]};
      send(w, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    end
    w = {ICD_PO_FPS, r[25:6], ICD_XO_SQRT, r[0]};
    send(w, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    w = {ICD_PO_FPD, r[25:6], ICD_XO_SQRT, r[0]};
    send(w, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    w = {ICD_PO_INTX, 15'h0, ICD_XO_TLBALL, 1'b0};
    send(w, 2'h0, ICD_CLASS_ILLEGAL, 2'h0);
    icd_fetch_model_inst.idle();
    send({6'h0e, r[25:0]}, 2'h0, ICD_CLASS_DEFINED, 2'h0);
    send({6'h20, r[25:0]}, 2'h0, ICD_CLASS_DEFINED, 2'h2);
    send({6'h32, r[25:0]}, 2'h0, ICD_CLASS_DEFINED, 2'h3);
    for (int k = 1; k < 4; k++) begin
      send({6'h0e, r[25:0]}, 2'(k), ICD_CLASS_DEFINED, 2'h0);
    end
    icd_fetch_model_inst.idle();
    repeat (3) @(posedge clk);
    chk("pending", 15'h0, 15'(notes.size()));
    tally_and_finish();
  end
endmodule // testbench
